// >>> hw/mlr_pkg.sv
// Purpose: Shared types and constants for the move/logic/rotate execution datapath.
// Assumes: 8-bit data, 7-bit data memory address, 16-bit program counter.
// Notes: Operation codes are this block's own decoded encoding, not opcode bits.
package mlr_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 16;
  localparam int STACK_DEPTH = 8;

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [1:0] LONG_CYCLES = 2'h2;
  localparam logic [1:0] SHORT_CYCLES = 2'h1;

  // ************************************************************
  // Status flag bit positions
  // ************************************************************
  localparam int FLG_CY = 0;
  localparam int FLG_HALF = 1;
  localparam int FLG_NULL = 2;
  localparam int FLG_WRAP = 3;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // ************************************************************
  // Operations handled by this datapath
  // ************************************************************
  typedef enum logic [4:0] {
    MLR_IDLE_OP                 = 5'h00,
    MLR_COPY_MEM_TO_ACC         = 5'h01,
    MLR_COPY_IMM_TO_ACC         = 5'h02,
    MLR_COPY_ACC_TO_MEM         = 5'h03,
    MLR_DISJ_ACC_MEM            = 5'h04,
    MLR_DISJ_ACC_IMM            = 5'h05,
    MLR_DISJ_TO_MEM_OP          = 5'h06,
    MLR_SUB_EXIT_OP             = 5'h07,
    MLR_SUB_EXIT_IMM            = 5'h08,
    MLR_IRQ_EXIT_OP             = 5'h09,
    MLR_SHIFT_CYC_LEFT          = 5'h0A,
    MLR_SHIFT_CYC_LEFT_ACC      = 5'h0B,
    MLR_SHIFT_LEFT_THRU_CY      = 5'h0C,
    MLR_SHIFT_LEFT_THRU_CY_ACC  = 5'h0D,
    MLR_SHIFT_CYC_RIGHT         = 5'h0E,
    MLR_SHIFT_CYC_RIGHT_ACC     = 5'h0F,
    MLR_SHIFT_RIGHT_THRU_CY     = 5'h10,
    MLR_SHIFT_RIGHT_THRU_CY_ACC = 5'h11,
    MLR_SUB_WITH_BORROW_ACC     = 5'h12,
    MLR_SUB_WITH_BORROW_MEM     = 5'h13,
    MLR_DEC_SKIP_ZERO           = 5'h14
  } mlr_op_t;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    mlr_op_t op;
    logic [7:0] imm;
    logic [6:0] addr;
  } mlr_instr_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } mlr_mem_wr_t;

  typedef struct packed {
    logic [7:0] res;
    logic [3:0] flags;
    logic [3:0] upd;
  } mlr_alu_res_t;

endpackage : mlr_pkg

// >>> hw/mlr_alu.sv
// Purpose: Combinational result and flag logic for logic, rotate and subtract ops.
// Assumes: Operand b is the memory byte or the instruction constant.
// Notes: upd marks which flags the operation writes; others are kept by the caller.
`timescale 1ns/1ps
module mlr_alu (
  // Operation and operands
  input wire mlr_pkg::mlr_op_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] opnd_i,
  input wire logic cy_i,
  // Result
  output mlr_pkg::mlr_alu_res_t res_o
);

  // ************************************************************
  // Arithmetic
  // ************************************************************
  logic [8:0] bw_sum;
  logic [4:0] bw_low;
  logic [7:0] disj;
  logic [7:0] rot_l;
  logic [7:0] rot_r;
  logic [7:0] rot_lc;
  logic [7:0] rot_rc;
  logic [7:0] dec_val;

  // Borrow form: acc + ~m + c, carry set means no borrow
  assign bw_sum = {1'b0, acc_i} + {1'b0, ~opnd_i} + {8'h00, cy_i};
  assign bw_low = {1'b0, acc_i[3:0]} + {1'b0, ~opnd_i[3:0]} + {4'h0, cy_i};
  assign disj = acc_i | opnd_i;
  assign rot_l = {opnd_i[6:0], opnd_i[7]};
  assign rot_r = {opnd_i[0], opnd_i[7:1]};
  assign rot_lc = {opnd_i[6:0], cy_i};
  assign rot_rc = {cy_i, opnd_i[7:1]};
  assign dec_val = opnd_i - 8'h01;

  function automatic logic null_of(input logic [7:0] v);
    null_of = (v == 8'h00);
  endfunction : null_of

  // ************************************************************
  // Selection
  // ************************************************************
  always_comb begin
    res_o.res = opnd_i;
    res_o.flags = 4'h0;
    res_o.upd = 4'h0;
    case (op_i)
      mlr_pkg::MLR_DISJ_ACC_MEM, mlr_pkg::MLR_DISJ_ACC_IMM,
      mlr_pkg::MLR_DISJ_TO_MEM_OP: begin
        res_o.res = disj;
        res_o.flags[mlr_pkg::FLG_NULL] = null_of(disj);
        res_o.upd[mlr_pkg::FLG_NULL] = 1'b1;
      end
      mlr_pkg::MLR_SHIFT_CYC_LEFT, mlr_pkg::MLR_SHIFT_CYC_LEFT_ACC: begin
        res_o.res = rot_l;
      end
      mlr_pkg::MLR_SHIFT_CYC_RIGHT, mlr_pkg::MLR_SHIFT_CYC_RIGHT_ACC: begin
        res_o.res = rot_r;
      end
      mlr_pkg::MLR_SHIFT_LEFT_THRU_CY, mlr_pkg::MLR_SHIFT_LEFT_THRU_CY_ACC: begin
        res_o.res = rot_lc;
        res_o.flags[mlr_pkg::FLG_CY] = opnd_i[7];
        res_o.upd[mlr_pkg::FLG_CY] = 1'b1;
      end
      mlr_pkg::MLR_SHIFT_RIGHT_THRU_CY, mlr_pkg::MLR_SHIFT_RIGHT_THRU_CY_ACC: begin
        res_o.res = rot_rc;
        res_o.flags[mlr_pkg::FLG_CY] = opnd_i[0];
        res_o.upd[mlr_pkg::FLG_CY] = 1'b1;
      end
      mlr_pkg::MLR_SUB_WITH_BORROW_ACC, mlr_pkg::MLR_SUB_WITH_BORROW_MEM: begin
        res_o.res = bw_sum[7:0];
        res_o.flags[mlr_pkg::FLG_CY] = bw_sum[8];
        res_o.flags[mlr_pkg::FLG_HALF] = bw_low[4];
        res_o.flags[mlr_pkg::FLG_NULL] = null_of(bw_sum[7:0]);
        // Signed wrap: acc and ~m of like sign give a result of other sign
        res_o.flags[mlr_pkg::FLG_WRAP] = (acc_i[7] == ~opnd_i[7]) &&
                                         (bw_sum[7] != acc_i[7]);
        res_o.upd = 4'hF;
      end
      mlr_pkg::MLR_DEC_SKIP_ZERO: begin
        res_o.res = dec_val;
      end
      default: begin
        res_o.res = opnd_i;
      end
    endcase
  end

endmodule : mlr_alu

// >>> hw/mlr_ret_stack.sv
// Purpose: Return address stack for the execution datapath.
// Assumes: Push and pop never occur in the same cycle.
// Notes: Overflow wraps and overwrites the oldest entry, as a small core stack does.
`timescale 1ns/1ps
module mlr_ret_stack #(
  parameter int DEPTH = mlr_pkg::STACK_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Stack access
  input wire logic push_i,
  input wire logic [15:0] push_pc_i,
  input wire logic pop_i,
  output logic [15:0] top_o
);

  localparam int PTR_W = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("Stack DEPTH must be a power of two, at least 2");
  end

  logic [15:0] mem_q [DEPTH];
  logic [PTR_W-1:0] ptr_q;
  logic [PTR_W-1:0] ptr_d;
  logic [PTR_W-1:0] top_idx;

  assign top_idx = ptr_q - PTR_W'(1);
  assign top_o = mem_q[top_idx];
  assign ptr_d = push_i ? ptr_q + PTR_W'(1) : (pop_i ? top_idx : ptr_q);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Entries hold no control state, so they need no reset
  always_ff @(posedge clk_i) begin
    if (push_i) begin
      mem_q[ptr_q] <= push_pc_i;
    end
  end

endmodule : mlr_ret_stack

// >>> hw/mlr_exec.sv
// Purpose: Executes copies, OR forms, returns, rotates, subtract-with-borrow and
//          decrement-skip; holds accumulator, status flags, PC and interrupt enable.
// Assumes: A fetch unit presents one decoded instruction with instr_valid_i and
//          the addressed memory byte on mem_rdata_i in the same cycle.
// Notes: Two-cycle instructions assert busy_o for their second cycle.
`timescale 1ns/1ps
module mlr_exec #(
  parameter int STACK_DEPTH = mlr_pkg::STACK_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Instruction in
  input wire logic instr_valid_i,
  input wire mlr_pkg::mlr_instr_t instr_i,
  output logic busy_o,
  // Data memory
  input wire logic [7:0] mem_rdata_i,
  output mlr_pkg::mlr_mem_wr_t mem_wr_o,
  // Call support from the rest of the core
  input wire logic call_push_i,
  input wire logic [15:0] call_target_i,
  // Interrupt enable control from the rest of the core
  input wire logic irq_take_i,
  // State out
  output logic [7:0] acc_o,
  output logic [3:0] flags_o,
  output logic [15:0] pc_o,
  output logic global_irq_enable_o,
  output logic discard_fetch_o
);

  if (STACK_DEPTH < 2) begin : g_bad_depth
    $error("STACK_DEPTH must be at least 2");
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [0:0] {
    MLR_ST_EXEC = 1'b0,
    MLR_ST_DUMMY = 1'b1
  } mlr_state_t;

  mlr_state_t state_q;
  mlr_state_t state_d;

  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic gie_q;
  logic gie_d;
  logic disc_q;
  logic disc_d;
  mlr_pkg::mlr_mem_wr_t wr_q;
  mlr_pkg::mlr_mem_wr_t wr_d;

  // ************************************************************
  // Decode
  // ************************************************************
  wire go = instr_valid_i && (state_q == MLR_ST_EXEC);
  mlr_pkg::mlr_op_t op;
  assign op = instr_i.op;

  wire use_imm = (op == mlr_pkg::MLR_DISJ_ACC_IMM);
  wire is_exit = (op == mlr_pkg::MLR_SUB_EXIT_OP) || (op == mlr_pkg::MLR_SUB_EXIT_IMM) ||
                (op == mlr_pkg::MLR_IRQ_EXIT_OP);
  wire to_acc = (op == mlr_pkg::MLR_DISJ_ACC_MEM) || (op == mlr_pkg::MLR_DISJ_ACC_IMM) ||
                (op == mlr_pkg::MLR_SHIFT_CYC_LEFT_ACC) ||
                (op == mlr_pkg::MLR_SHIFT_LEFT_THRU_CY_ACC) ||
                (op == mlr_pkg::MLR_SHIFT_CYC_RIGHT_ACC) ||
                (op == mlr_pkg::MLR_SHIFT_RIGHT_THRU_CY_ACC) ||
                (op == mlr_pkg::MLR_SUB_WITH_BORROW_ACC);
  wire to_mem = (op == mlr_pkg::MLR_DISJ_TO_MEM_OP) ||
                (op == mlr_pkg::MLR_SHIFT_CYC_LEFT) ||
                (op == mlr_pkg::MLR_SHIFT_LEFT_THRU_CY) ||
                (op == mlr_pkg::MLR_SHIFT_CYC_RIGHT) ||
                (op == mlr_pkg::MLR_SHIFT_RIGHT_THRU_CY) ||
                (op == mlr_pkg::MLR_SUB_WITH_BORROW_MEM) ||
                (op == mlr_pkg::MLR_DEC_SKIP_ZERO);

  // ************************************************************
  // Datapath
  // ************************************************************
  logic [7:0] opnd;
  mlr_pkg::mlr_alu_res_t alu;
  logic [15:0] stack_top;

  assign opnd = use_imm ? instr_i.imm : mem_rdata_i;

  mlr_alu u_alu (
    .op_i(op),
    .acc_i(acc_q),
    .opnd_i(opnd),
    .cy_i(flags_q[mlr_pkg::FLG_CY]),
    .res_o(alu)
  );

  mlr_ret_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .push_i(call_push_i),
    .push_pc_i(pc_q + 16'h0001),
    .pop_i(go && is_exit),
    .top_o(stack_top)
  );

  // Zero after decrement decides the skip
  wire dec_zero = (op == mlr_pkg::MLR_DEC_SKIP_ZERO) && (alu.res == 8'h00);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    acc_d = acc_q;
    pc_d = pc_q;
    gie_d = gie_q;
    state_d = MLR_ST_EXEC;
    disc_d = 1'b0;
    wr_d = '{we: 1'b0, addr: instr_i.addr, wdata: alu.res};
    // Only flags marked by the ALU change; the rest keep their value
    flags_d = (flags_q & ~alu.upd) | (alu.flags & alu.upd);
    if (!go) begin
      flags_d = flags_q;
    end
    if (irq_take_i) begin
      gie_d = 1'b0;
    end
    if (go) begin
      pc_d = pc_q + 16'h0001;
      case (op)
        mlr_pkg::MLR_COPY_MEM_TO_ACC: begin
          acc_d = mem_rdata_i;
        end
        mlr_pkg::MLR_COPY_IMM_TO_ACC: begin
          acc_d = instr_i.imm;
        end
        mlr_pkg::MLR_COPY_ACC_TO_MEM: begin
          wr_d.we = 1'b1;
          wr_d.wdata = acc_q;
        end
        mlr_pkg::MLR_SUB_EXIT_OP: begin
          pc_d = stack_top;
          state_d = MLR_ST_DUMMY;
        end
        mlr_pkg::MLR_SUB_EXIT_IMM: begin
          pc_d = stack_top;
          acc_d = instr_i.imm;
          state_d = MLR_ST_DUMMY;
        end
        mlr_pkg::MLR_IRQ_EXIT_OP: begin
          pc_d = stack_top;
          gie_d = 1'b1;
          state_d = MLR_ST_DUMMY;
        end
        mlr_pkg::MLR_DEC_SKIP_ZERO: begin
          wr_d.we = 1'b1;
          if (dec_zero) begin
            pc_d = pc_q + 16'h0002;
            disc_d = 1'b1;
            state_d = MLR_ST_DUMMY;
          end
        end
        default: begin
          if (to_acc) begin
            acc_d = alu.res;
          end
          if (to_mem) begin
            wr_d.we = 1'b1;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= MLR_ST_EXEC;
      acc_q <= mlr_pkg::ACC_RST;
      flags_q <= mlr_pkg::FLAGS_RST;
      pc_q <= mlr_pkg::PC_RST;
      gie_q <= 1'b0;
      disc_q <= 1'b0;
      wr_q <= '0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      pc_q <= call_push_i ? call_target_i : pc_d;
      gie_q <= gie_d;
      disc_q <= disc_d;
      wr_q <= wr_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Second cycle of a return or of a taken skip refuses new work
  assign busy_o = (state_q == MLR_ST_DUMMY);
  assign mem_wr_o = wr_q;
  assign acc_o = acc_q;
  assign flags_o = flags_q;
  assign pc_o = pc_q;
  assign global_irq_enable_o = gie_q;
  assign discard_fetch_o = disc_q;

endmodule : mlr_exec

// >>> test/mlr_exec_properties.sv
// Purpose: Port checks for the execution datapath
// Assumes: One clock, async active-low reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module mlr_exec_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Inputs
  input wire logic instr_valid_i,
  input wire mlr_pkg::mlr_instr_t instr_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic call_push_i,
  input wire logic [15:0] call_target_i,
  input wire logic irq_take_i,
  // Outputs
  input wire logic busy_o,
  input wire mlr_pkg::mlr_mem_wr_t mem_wr_o,
  input wire logic [7:0] acc_o,
  input wire logic [3:0] flags_o,
  input wire logic [15:0] pc_o,
  input wire logic global_irq_enable_o,
  input wire logic discard_fetch_o
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire go;
  wire [4:0] op;
  // Call load wins over the pc update, so leave those cycles out
  assign go = instr_valid_i && !busy_o && !call_push_i;
  assign op = instr_i.op;
  property p_mem;
    go && op == 5'h01 |=> acc_o == $past(mem_rdata_i) && $stable(flags_o);
  endproperty
  a_mem: assert property (p_mem) else $error("mem copy");
  property p_imm;
    go && op == 5'h02 |=> acc_o == $past(instr_i.imm) && $stable(flags_o);
  endproperty
  a_imm: assert property (p_imm) else $error("imm copy");
  property p_st;
    go && op == 5'h03 |=> mem_wr_o == {1'b1, $past(instr_i.addr), $past(acc_o)};
  endproperty
  a_st: assert property (p_st) else $error("store");
  property p_idle;
    go && op == 5'h00 |=> pc_o == $past(pc_o) + 16'h0001 && $stable(acc_o) && !mem_wr_o.we;
  endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_disj_mem;
    go && op == 5'h06 |=> mem_wr_o.wdata == ($past(acc_o) | $past(mem_rdata_i))
      && flags_o[2] == (mem_wr_o.wdata == 8'h00);
  endproperty
  a_disj_mem: assert property (p_disj_mem) else $error("or to mem");
  property p_sub_exit;
    go && op == 5'h07 |=> busy_o && $stable(flags_o) ##1 !busy_o;
  endproperty
  a_sub_exit: assert property (p_sub_exit) else $error("sub exit");
  property p_rti;
    go && op == 5'h09 |=> global_irq_enable_o;
  endproperty
  a_rti: assert property (p_rti) else $error("irq exit");
  property p_cyc_left_acc;
    go && op == 5'h0B |=> acc_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])}
      && !mem_wr_o.we;
  endproperty
  a_cyc_left_acc: assert property (p_cyc_left_acc) else $error("rotate acc");
  property p_skp;
    go && op == 5'h14 && mem_rdata_i == 8'h01 |=> discard_fetch_o && busy_o
      ##1 !discard_fetch_o && !busy_o;
  endproperty
  a_skp: assert property (p_skp) else $error("skip");
endmodule : mlr_exec_properties

// >>> test/mlr_exec_tb_top.sv
// Purpose: Directed bench for the execution datapath
// Assumes: Bench acts as memory and fetch unit
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module mlr_exec_tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic instr_valid_i = 1'b0;
  mlr_pkg::mlr_instr_t instr_i = '0;
  logic [7:0] mem_rdata_i = 8'h00;
  logic call_push_i = 1'b0;
  logic [15:0] call_target_i = 16'h0000;
  logic irq_take_i = 1'b0;
  logic busy_o;
  mlr_pkg::mlr_mem_wr_t mem_wr_o;
  logic [7:0] acc_o;
  logic [3:0] flags_o;
  logic [15:0] pc_o;
  logic global_irq_enable_o;
  logic discard_fetch_o;
  int bad_count = 0;
  int checked = 0;
  logic [15:0] e_pc = 16'h0000;
  logic [3:0] e_flg = 4'h0;
  always #5 clk_i = ~clk_i;
  mlr_exec i_mlr_exec (
    .clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .busy_o(busy_o), .mem_rdata_i(mem_rdata_i),
    .mem_wr_o(mem_wr_o), .call_push_i(call_push_i), .call_target_i(call_target_i),
    .irq_take_i(irq_take_i), .acc_o(acc_o), .flags_o(flags_o), .pc_o(pc_o),
    .global_irq_enable_o(global_irq_enable_o), .discard_fetch_o(discard_fetch_o)
  );
  // ********
  // Helpers
  // ********
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic chk8(input logic [7:0] s, input logic [7:0] e);
    chk({8'h00, s}, {8'h00, e});
  endtask : chk8
  task automatic chk_flg();
    chk8({4'h0, flags_o}, {4'h0, e_flg});
  endtask : chk_flg
  task automatic adv(input logic [15:0] n);
    e_pc = e_pc + n;
    chk(pc_o, e_pc);
  endtask : adv
  // Address is the inverted constant, so stores show it
  task automatic issue(input logic [4:0] op, input logic [7:0] imm, input logic [7:0] m);
    instr_valid_i = 1'b1;
    instr_i = {op, imm, ~imm[6:0]};
    mem_rdata_i = m;
    @(negedge clk_i);
  endtask : issue
  task automatic drop();
    instr_valid_i = 1'b0;
    @(negedge clk_i);
  endtask : drop
  task automatic push(input logic [15:0] t);
    call_push_i = 1'b1;
    call_target_i = t;
    @(negedge clk_i);
    call_push_i = 1'b0;
    chk(pc_o, t);
  endtask : push
  function automatic logic [8:0] rot(input logic [1:0] k, input logic [7:0] m, input logic c);
    case (k)
      2'h0: rot = {c, m[6:0], m[7]};
      2'h1: rot = {m[7], m[6:0], c};
      2'h2: rot = {c, m[0], m[7:1]};
      default: rot = {m[0], c, m[7:1]};
    endcase
  endfunction : rot
  // ********
  // Scenarios
  // ********
  task automatic t_copy();
    chk({acc_o, flags_o, busy_o, mem_wr_o.we, discard_fetch_o, global_irq_enable_o}, 16'h0000);
    issue(5'h02, 8'hA5, 8'h5A);
    chk8(acc_o, 8'hA5);
    issue(5'h01, 8'h00, 8'h3C);
    chk8(acc_o, 8'h3C);
    chk_flg();
    issue(5'h03, 8'h12, 8'hFF);
    chk(mem_wr_o, {1'b1, 7'h6D, 8'h3C});
    issue(5'h00, 8'h00, 8'h00);
    adv(16'h0004);
    chk8({acc_o[6:0], mem_wr_o.we}, 8'h78);
    drop();
  endtask : t_copy
  task automatic t_or();
    issue(5'h02, 8'h00, 8'h00);
    issue(5'h06, 8'h00, 8'h00);
    e_flg[2] = 1'b1;
    chk(mem_wr_o, {1'b1, 7'h7F, 8'h00});
    chk_flg();
    issue(5'h04, 8'h00, 8'h81);
    e_flg[2] = 1'b0;
    chk8(acc_o, 8'h81);
    chk_flg();
    issue(5'h02, 8'h00, 8'h00);
    issue(5'h05, 8'h00, 8'hFF);
    e_flg[2] = 1'b1;
    chk8(acc_o, 8'h00);
    chk_flg();
    adv(16'h0005);
    drop();
  endtask : t_or
  // Odd codes write the accumulator, even ones memory
  task automatic t_rot();
    logic [8:0] r;
    logic [7:0] a;
    logic [7:0] m;
    for (int k = 0; k < 16; k++) begin
      m = k[3] ? 8'h59 : 8'hA6;
      a = acc_o;
      r = rot(k[2:1], m, e_flg[0]);
      issue(5'h0A + {2'h0, k[2:0]}, 8'h00, m);
      e_flg[0] = r[8];
      chk_flg();
      if (k[0]) begin
        chk({acc_o, 7'h00, mem_wr_o.we}, {r[7:0], 8'h00});
      end else begin
        chk(mem_wr_o, {1'b1, 7'h7F, r[7:0]});
        chk8(acc_o, a);
      end
    end
    adv(16'h0010);
    drop();
  endtask : t_rot
  task automatic do_borrow(input logic [4:0] op, input logic [7:0] a, input logic [7:0] m);
    logic [8:0] s;
    logic [4:0] h;
    issue(5'h02, a, 8'h00);
    s = {1'b0, a} + {1'b0, ~m} + {8'h00, e_flg[0]};
    h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, e_flg[0]};
    e_flg = {(a[7] == ~m[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
    issue(op, 8'h00, m);
    chk_flg();
    if (op[0]) chk(mem_wr_o, {1'b1, 7'h7F, s[7:0]});
    else chk8(acc_o, s[7:0]);
    adv(16'h0002);
  endtask : do_borrow
  task automatic t_exit();
    logic [15:0] rp;
    logic [7:0] ka;
    rp = e_pc + 16'h0001;
    ka = acc_o;
    push(16'h1234);
    issue(5'h07, 8'h00, 8'h00);
    chk({pc_o[14:0], busy_o}, {rp[14:0], 1'b1});
    issue(5'h02, 8'h77, 8'h00);
    chk({acc_o, 7'h00, busy_o}, {ka, 8'h00});
    chk(pc_o, rp);
    drop();
    push(16'h2000);
    issue(5'h08, 8'h5A, 8'h00);
    chk({pc_o[7:0], acc_o}, {rp[7:0] + 8'h01, 8'h5A});
    chk_flg();
    drop();
    push(16'h3000);
    issue(5'h09, 8'h00, 8'h00);
    chk({pc_o[14:0], global_irq_enable_o}, {rp[14:0] + 15'h0002, 1'b1});
    drop();
    irq_take_i = 1'b1;
    @(negedge clk_i);
    irq_take_i = 1'b0;
    chk8({7'h00, global_irq_enable_o}, 8'h00);
    e_pc = rp + 16'h0002;
  endtask : t_exit
  task automatic t_skip();
    issue(5'h14, 8'h00, 8'h01);
    chk(mem_wr_o, {1'b1, 7'h7F, 8'h00});
    adv(16'h0002);
    chk8({6'h00, busy_o, discard_fetch_o}, 8'h03);
    drop();
    chk8({6'h00, busy_o, discard_fetch_o}, 8'h00);
    issue(5'h14, 8'h00, 8'h05);
    chk(mem_wr_o, {1'b1, 7'h7F, 8'h04});
    issue(5'h14, 8'h00, 8'h00);
    chk({mem_wr_o.wdata, 6'h00, busy_o, discard_fetch_o}, 16'hFF00);
    adv(16'h0002);
    chk_flg();
    drop();
  endtask : t_skip
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    nrst_i = 1'b1;
    t_copy();
    t_or();
    t_rot();
    do_borrow(5'h12, 8'h80, 8'h01);
    do_borrow(5'h12, 8'h50, 8'h50);
    do_borrow(5'h13, 8'h10, 8'h20);
    do_borrow(5'h13, 8'h05, 8'h05);
    drop();
    t_exit();
    t_skip();
    wrap_up();
  end
  // Whole run is about 55 cycles
  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end
endmodule : mlr_exec_tb_top
bind mlr_exec mlr_exec_properties i_mlr_exec_properties (
  .clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .mem_rdata_i(mem_rdata_i), .call_push_i(call_push_i), .call_target_i(call_target_i),
  .irq_take_i(irq_take_i), .busy_o(busy_o), .mem_wr_o(mem_wr_o), .acc_o(acc_o),
  .flags_o(flags_o), .pc_o(pc_o), .global_irq_enable_o(global_irq_enable_o),
  .discard_fetch_o(discard_fetch_o)
);
